// File: common/i2cs_pkg.sv
/*
 * Shared constants and types of the two-wire configuration slave:
 * slave address, register indices, initial values, bit counts and link states.
 * Assumes a SystemVerilog compiler; no clocking or timing is implied here.
 */
`default_nettype none

package i2cs_pkg;

    localparam int REG_COUNT = 3;
    localparam int REG_W = 8;

    // Fixed seven-bit slave address 1000110
    localparam logic [6:0] SLAVE_ADDR = 7'h46;

    // Register indices; IDX_NONE marks a pointer run past the last register
    localparam logic [1:0] IDX_NB = 2'h0;
    localparam logic [1:0] IDX_CORE = 2'h1;
    localparam logic [1:0] IDX_PSM = 2'h2;
    localparam logic [1:0] IDX_NONE = 2'h3;
    localparam logic [7:0] PTR_LIMIT = 8'h02;

    // Initial register values
    localparam logic [7:0] INIT_NB = 8'h00;
    localparam logic [7:0] INIT_CORE = 8'h00;
    localparam logic [7:0] INIT_PSM = 8'h01;

    // Byte sent when the pointer has no register behind it
    localparam logic [7:0] IDLE_BYTE = 8'hff;

    // Bit counter marks
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_LOAD = 4'h9;

    // Position of the direction bit in the control byte
    localparam int RW_POS = 0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CTRL = 3'b001,
        ST_PTR = 3'b010,
        ST_WDATA = 3'b011,
        ST_TX = 3'b100,
        ST_RACK = 3'b101,
        ST_SKIP = 3'b110
    } i2cs_state_type;

endpackage

`default_nettype wire

// File: rtl/i2cs_sync.sv
/*
 * Two-flop synchroniser for levels entering a clock domain.
 * Assumes the input is a level that stays put for several destination cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module i2cs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_reg <= RST_VAL;
            q_reg <= RST_VAL;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;

endmodule

`default_nettype wire

// File: rtl/i2cs_cfg_top.sv
/*
 * Slave-only two-wire interface holding three 8-bit regulator configuration
 * registers; link logic on CLK_LINK, values cross to CLK_SYS by a toggle at STOP.
 * Assumes CLK_LINK runs freely and is much faster than SCL; SDA is open drain.
 */
// Summary of operation
// - Answer only slave address 1000110
// - Support register write and current-address read
// - Pull data low on address match
// - Pointer byte follows write control byte
// - Pointers 0,1,2 select the three registers
// - Single write: control, pointer, data, STOP
// - Apply written values when transaction completes
// - Sequential write steps to following registers
// - Read control byte gets ack, then data
// - Master ack advances read to next register
// - Initial values 0x00, 0x00, 0x01
// - Power-on reset restores initial values
// - Writing initial values restores state harmlessly
// - START/STOP while clock high; data changes low
// - Nine clocks per byte, ninth is ack
// - Most significant bit first
`timescale 1ns/1ps
`default_nettype none

module i2cs_cfg_top
    import i2cs_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CLK_LINK,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    output logic [REG_W-1:0] NB_OFFSET_OVP_PGOOD_CFG,
    output logic [REG_W-1:0] CORE_OFFSET_OVP_PGOOD_CFG,
    output logic [REG_W-1:0] POWER_SAVE_MODE_CFG,
    output logic CFG_UPDATE
);

    // Link domain
    logic rst_link;
    logic scl_s;
    logic sda_s;

    i2cs_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_rst_sync (
        .clk(CLK_LINK),
        .rst(1'b0),
        .d(RST),
        .q(rst_link)
    );
    i2cs_sync #(.WIDTH(2), .RST_VAL(2'b11)) u_pin_sync (
        .clk(CLK_LINK),
        .rst(rst_link),
        .d({SCL_IN, SDA_IN}),
        .q({scl_s, sda_s})
    );
    i2cs_state_type state_reg, state_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic ack_phase_reg, ack_phase_next;
    logic sda_oe_reg, sda_oe_next;
    logic [1:0] ptr_reg, ptr_next;
    logic dirty_reg, dirty_next;
    logic upd_tgl_reg, upd_tgl_next;
    logic scl_d_reg, sda_d_reg;
    logic [7:0] cfg_reg [REG_COUNT];
    logic [7:0] cfg_next [REG_COUNT];
    logic [7:0] xfer_reg [REG_COUNT];
    logic [7:0] xfer_next [REG_COUNT];

    logic scl_rise, scl_fall, start_det, stop_det, load_tx;
    logic [7:0] tx_src;

    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    assign tx_src = (ptr_reg == IDX_NONE) ? IDLE_BYTE : cfg_reg[ptr_reg];
    assign load_tx = scl_fall && (state_reg == ST_TX) && (ack_phase_reg || bit_cnt_reg == BIT_LOAD);

    always_comb begin
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        ack_phase_next = ack_phase_reg;
        sda_oe_next = sda_oe_reg;
        ptr_next = ptr_reg;
        dirty_next = dirty_reg;
        upd_tgl_next = upd_tgl_reg;
        cfg_next = cfg_reg;
        xfer_next = xfer_reg;
        if (start_det) begin
            // Also a repeated START: restart on a control byte
            state_next = ST_CTRL;
            bit_cnt_next = '0;
            ack_phase_next = 1'b0;
            sda_oe_next = 1'b0;
        end else if (stop_det) begin
            state_next = ST_IDLE;
            ack_phase_next = 1'b0;
            sda_oe_next = 1'b0;
            if (dirty_reg) begin
                dirty_next = 1'b0;
                upd_tgl_next = ~upd_tgl_reg;
                xfer_next = cfg_reg;
            end
        end else if (ack_phase_reg) begin
            if (scl_fall) begin
                // Ninth clock over: release the line, or drive the top bit of a read byte
                ack_phase_next = 1'b0;
                sda_oe_next = 1'b0;
                bit_cnt_next = '0;
                if (load_tx) begin
                    shift_next = tx_src;
                    sda_oe_next = ~tx_src[7];
                end
            end
        end else begin
            case (state_reg)
                ST_CTRL, ST_PTR, ST_WDATA: begin
                    if (scl_rise && bit_cnt_reg != BIT_LAST) begin
                        shift_next = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == BIT_LAST) begin
                        if (state_reg == ST_CTRL) begin
                            if (shift_reg[7:1] == SLAVE_ADDR) begin
                                ack_phase_next = 1'b1;
                                sda_oe_next = 1'b1;
                                state_next = shift_reg[RW_POS] ? ST_TX : ST_PTR;
                            end else begin
                                state_next = ST_SKIP;
                            end
                        end else if (state_reg == ST_PTR) begin
                            if (shift_reg <= PTR_LIMIT) begin
                                ack_phase_next = 1'b1;
                                sda_oe_next = 1'b1;
                                ptr_next = shift_reg[1:0];
                                state_next = ST_WDATA;
                            end else begin
                                state_next = ST_SKIP;
                            end
                        end else begin
                            if (ptr_reg != IDX_NONE) begin
                                ack_phase_next = 1'b1;
                                sda_oe_next = 1'b1;
                                cfg_next[ptr_reg] = shift_reg;
                                dirty_next = 1'b1;
                                ptr_next = ptr_reg + 2'h1;
                            end else begin
                                state_next = ST_SKIP;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (load_tx) begin
                        shift_next = tx_src;
                        sda_oe_next = ~tx_src[7];
                        bit_cnt_next = '0;
                    end else if (scl_rise) begin
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == BIT_LAST) begin
                            sda_oe_next = 1'b0;
                            state_next = ST_RACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            sda_oe_next = ~shift_reg[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        if (!sda_s) begin
                            state_next = ST_TX;
                            bit_cnt_next = BIT_LOAD;
                            if (ptr_reg != IDX_NONE) begin
                                ptr_next = ptr_reg + 2'h1;
                            end
                        end else begin
                            state_next = ST_SKIP;
                        end
                    end
                end
                default: begin
                    state_next = state_reg;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_LINK) begin
        if (rst_link) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= '0;
            shift_reg <= '0;
            ack_phase_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            ptr_reg <= IDX_NB;
            dirty_reg <= 1'b0;
            upd_tgl_reg <= 1'b0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            cfg_reg <= '{INIT_NB, INIT_CORE, INIT_PSM};
            xfer_reg <= '{INIT_NB, INIT_CORE, INIT_PSM};
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            ack_phase_reg <= ack_phase_next;
            sda_oe_reg <= sda_oe_next;
            ptr_reg <= ptr_next;
            dirty_reg <= dirty_next;
            upd_tgl_reg <= upd_tgl_next;
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            cfg_reg <= cfg_next;
            xfer_reg <= xfer_next;
        end
    end

    // Open drain: only ever pulls low, never touches the clock line
    assign SDA_OUT = 1'b0;
    assign SDA_OE = sda_oe_reg;

    // System domain
    logic tgl_s;
    logic tgl_seen_reg, tgl_seen_next;
    logic [7:0] nb_reg, nb_next;
    logic [7:0] core_reg, core_next;
    logic [7:0] psm_reg, psm_next;
    logic update_reg, update_next;
    i2cs_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_tgl_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .d(upd_tgl_reg),
        .q(tgl_s)
    );
    always_comb begin
        tgl_seen_next = tgl_seen_reg;
        nb_next = nb_reg;
        core_next = core_reg;
        psm_next = psm_reg;
        update_next = 1'b0;
        if (tgl_s != tgl_seen_reg) begin
            // Held words are stable long before the toggle arrives
            tgl_seen_next = tgl_s;
            nb_next = xfer_reg[IDX_NB];
            core_next = xfer_reg[IDX_CORE];
            psm_next = xfer_reg[IDX_PSM];
            update_next = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            tgl_seen_reg <= 1'b0;
            nb_reg <= INIT_NB;
            core_reg <= INIT_CORE;
            psm_reg <= INIT_PSM;
            update_reg <= 1'b0;
        end else begin
            tgl_seen_reg <= tgl_seen_next;
            nb_reg <= nb_next;
            core_reg <= core_next;
            psm_reg <= psm_next;
            update_reg <= update_next;
        end
    end

    assign NB_OFFSET_OVP_PGOOD_CFG = nb_reg;
    assign CORE_OFFSET_OVP_PGOOD_CFG = core_reg;
    assign POWER_SAVE_MODE_CFG = psm_reg;
    assign CFG_UPDATE = update_reg;
    // Checks
    sequence seq_byte_end;
        !ack_phase_reg && scl_fall && bit_cnt_reg == BIT_LAST;
    endsequence
    sequence seq_ack_then_release;
        (sda_oe_reg && ack_phase_reg) ##[1:1000] !ack_phase_reg;
    endsequence
    AST_NACK_FOREIGN: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        (state_reg == ST_CTRL && shift_reg[7:1] != SLAVE_ADDR && !start_det && !stop_det) ##0 seq_byte_end
        |=> !sda_oe_reg && state_reg == ST_SKIP) else $error("foreign address was answered");
    AST_ACK_MATCH: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        (state_reg == ST_CTRL && shift_reg[7:1] == SLAVE_ADDR && !start_det && !stop_det) ##0 seq_byte_end
        |=> seq_ack_then_release) else $error("own address not acknowledged and released");
    AST_ACK_HELD: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        ack_phase_reg |-> sda_oe_reg) else $error("acknowledge released early");
    AST_PTR_REFUSE: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        (state_reg == ST_PTR && shift_reg > PTR_LIMIT && !start_det && !stop_det) ##0 seq_byte_end
        |=> !sda_oe_reg && $stable(ptr_reg) && state_reg == ST_SKIP) else $error("out of range pointer accepted");
    AST_PTR_SET: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        (state_reg == ST_PTR && shift_reg <= PTR_LIMIT && !start_det && !stop_det) ##0 seq_byte_end
        |=> {6'h00, ptr_reg} == $past(shift_reg) && state_reg == ST_WDATA && sda_oe_reg) else $error("pointer not set");
    AST_WRITE_STEP: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        (state_reg == ST_WDATA && ptr_reg != IDX_NONE && !start_det && !stop_det) ##0 seq_byte_end
        |=> ptr_reg == $past(ptr_reg) + 2'h1 && dirty_reg && cfg_reg[$past(ptr_reg)] == $past(shift_reg))
        else $error("data byte did not land and advance");
    AST_STOP_COMMIT: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        (stop_det && dirty_reg) |=> (upd_tgl_reg != $past(upd_tgl_reg)) && !dirty_reg && state_reg == ST_IDLE)
        else $error("stop after write did not commit");
    AST_APPLY_PULSE: assert property (@(posedge CLK_SYS) disable iff (RST)
        (tgl_s != tgl_seen_reg) |=> CFG_UPDATE && POWER_SAVE_MODE_CFG == xfer_reg[IDX_PSM] ##1 !CFG_UPDATE)
        else $error("commit not applied in one cycle");
    AST_RESET_INIT: assert property (@(posedge CLK_SYS) disable iff (RST)
        $fell(RST) |-> NB_OFFSET_OVP_PGOOD_CFG == INIT_NB && CORE_OFFSET_OVP_PGOOD_CFG == INIT_CORE
            && POWER_SAVE_MODE_CFG == INIT_PSM && !CFG_UPDATE)
        else $error("outputs not at initial values after reset");
    AST_OE_WHILE_LOW: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        ($changed(sda_oe_reg) && !$past(start_det) && !$past(stop_det)) |-> !scl_s)
        else $error("data line drive changed while clock high");
    AST_START_RESTART: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        start_det |=> state_reg == ST_CTRL && bit_cnt_reg == 4'h0 && !sda_oe_reg)
        else $error("start did not restart the control byte");
    AST_READ_MSB: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        (load_tx && !start_det && !stop_det) |=> shift_reg == $past(tx_src) && sda_oe_reg == ~shift_reg[7])
        else $error("read byte not started with its top bit");
    AST_MASTER_ACK: assert property (@(posedge CLK_LINK) disable iff (rst_link)
        (state_reg == ST_RACK && scl_rise && !start_det && !stop_det)
        |=> (state_reg == (($past(sda_s)) ? ST_SKIP : ST_TX))) else $error("master acknowledge handled wrongly");

endmodule

`default_nettype wire

// File: dv/i2cs_master_model.sv
/*
 * Behavioural two-wire bus master: makes SCL and pulls SDA low, open drain.
 * Assumes the bench resolves the SDA wire with a pull-up and feeds it back.
 */
`timescale 1ns/1ps
`default_nettype none

module i2cs_master_model
    import i2cs_pkg::*;
#(
    parameter int HALF = 68
) (
    input wire logic clk,
    input wire logic sda_wire,
    output var logic scl,
    output var logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_q(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Data moves only while SCL is low
    task automatic bit_io(input logic b_out, output logic b_in);
        wait_q(HALF / 2);
        sda_low = ~b_out;
        wait_q(HALF / 2);
        scl = 1'b1;
        wait_q(HALF / 2);
        b_in = sda_wire;
        wait_q(HALF / 2);
        scl = 1'b0;
    endtask

    task automatic start_cond();
        wait_q(HALF / 2);
        sda_low = 1'b0;
        wait_q(HALF / 2);
        scl = 1'b1;
        wait_q(HALF);
        sda_low = 1'b1;
        wait_q(HALF);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        wait_q(HALF / 2);
        sda_low = 1'b1;
        wait_q(HALF / 2);
        scl = 1'b1;
        wait_q(HALF);
        sda_low = 1'b0;
        wait_q(HALF);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack_n);
        logic dummy;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], dummy);
        end
        bit_io(1'b1, ack_n);
    endtask

    task automatic recv_byte(input logic more, output logic [7:0] b);
        logic dummy;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(~more, dummy);
    endtask

    // Control byte, pointer, data bytes; gives up after a refusal
    task automatic write_xfer(input logic [6:0] addr, input int n, input logic [31:0] bytes,
                              output logic [4:0] ack_n);
        logic a;
        ack_n = 5'h1f;
        start_cond();
        send_byte({addr, 1'b0}, a);
        ack_n[0] = a;
        for (int i = 0; i < n && a === 1'b0; i++) begin
            send_byte(bytes[31 - 8 * i -: 8], a);
            ack_n[i + 1] = a;
        end
        stop_cond();
    endtask

    task automatic read_xfer(input int n, output logic [23:0] data, output logic ack_n);
        logic [7:0] b;
        data = 24'h0;
        start_cond();
        send_byte({SLAVE_ADDR, 1'b1}, ack_n);
        for (int i = 0; i < n && ack_n === 1'b0; i++) begin
            recv_byte(i < n - 1, b);
            data[23 - 8 * i -: 8] = b;
        end
        stop_cond();
    endtask
endmodule

`default_nettype wire

// File: dv/testbench.sv
/*
 * Self-checking bench of the configuration slave, driven through the master model.
 * Assumes the design's own assertions watch the wire timing.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import i2cs_pkg::*;
    logic CLK_SYS, RST, CLK_LINK;
    logic scl, mst_sda_low, sda_wire, sda_out, sda_oe, cfg_update;
    logic [7:0] nb_cfg, core_cfg, psm_cfg;
    logic [4:0] ack_n;
    logic [23:0] rdat;
    logic rack;
    int bad_count = 0;
    int n_checks = 0;
    int upd_count = 0;
    int upd_base;
    logic [6:0] bad_addr [3] = '{7'h47, 7'h06, 7'h66};
    logic [7:0] bad_ptr [2] = '{8'h03, 8'h80};

    // Pull-up wire: low if anyone pulls
    assign sda_wire = (mst_sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

    i2cs_cfg_top u_i2cs_cfg_top (.CLK_SYS(CLK_SYS), .RST(RST), .CLK_LINK(CLK_LINK), .SCL_IN(scl),
        .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .NB_OFFSET_OVP_PGOOD_CFG(nb_cfg),
        .CORE_OFFSET_OVP_PGOOD_CFG(core_cfg), .POWER_SAVE_MODE_CFG(psm_cfg), .CFG_UPDATE(cfg_update));

    i2cs_master_model u_i2cs_master_model (.clk(CLK_SYS), .sda_wire(sda_wire), .scl(scl),
        .sda_low(mst_sda_low));

    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    initial begin
        CLK_LINK = 1'b0;
        #7.3;
        forever #16 CLK_LINK = ~CLK_LINK;
    end

    always @(posedge CLK_SYS) begin
        if (cfg_update === 1'b1) begin
            upd_count <= upd_count + 1;
        end
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic outs(input logic [23:0] exp);
        check({nb_cfg, core_cfg, psm_cfg}, exp);
    endtask

    // Write transfer, then acks and count of update pulses
    task automatic wr(input logic [6:0] a, input int n, input logic [31:0] b, input logic [4:0] exp_ack,
                      input int exp_upd);
        upd_base = upd_count;
        u_i2cs_master_model.write_xfer(a, n, b, ack_n);
        repeat (100) @(negedge CLK_SYS);
        check({19'h0, ack_n}, {19'h0, exp_ack});
        check(24'(upd_count - upd_base), 24'(exp_upd));
    endtask

    task automatic rd(input int n, input logic [23:0] exp);
        u_i2cs_master_model.read_xfer(n, rdat, rack);
        check({23'h0, rack}, 24'h0);
        check(rdat, exp);
    endtask

    task automatic end_test(input string name);
        $display("test %s finished, mismatches so far %0d", name, bad_count);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge CLK_SYS);
        bad_count++;
        $display("watchdog expired");
        give_verdict();
    end

    initial begin
        RST = 1'b1;
        repeat (20) @(negedge CLK_SYS);
        RST = 1'b0;
        repeat (40) @(negedge CLK_SYS);
        outs(24'h000001);
        check({23'h0, sda_oe}, 24'h0);
        check({23'h0, sda_out}, 24'h0);
        end_test("reset values");
        wr(SLAVE_ADDR, 1, 32'h00000000, 5'h1c, 0);
        rd(3, 24'h000001);
        end_test("initial readback");
        wr(SLAVE_ADDR, 2, 32'h01120000, 5'h18, 1);
        outs(24'h001201);
        wr(SLAVE_ADDR, 1, 32'h01000000, 5'h1c, 0);
        rd(1, 24'h120000);
        end_test("single write");
        wr(SLAVE_ADDR, 4, 32'h00c85b37, 5'h00, 1);
        outs(24'hc85b37);
        wr(SLAVE_ADDR, 1, 32'h00000000, 5'h1c, 0);
        rd(3, 24'hc85b37);
        wr(SLAVE_ADDR, 3, 32'h00a1b200, 5'h10, 1);
        outs(24'ha1b237);
        end_test("sequential write");
        foreach (bad_addr[i]) begin
            wr(bad_addr[i], 2, 32'h00ff0000, 5'h1f, 0);
        end
        foreach (bad_ptr[i]) begin
            wr(SLAVE_ADDR, 2, {bad_ptr[i], 24'hee0000}, 5'h1e, 0);
        end
        outs(24'ha1b237);
        rd(1, 24'h370000);
        end_test("refusals");
        wr(SLAVE_ADDR, 4, 32'h00000001, 5'h00, 1);
        outs(24'h000001);
        end_test("restore by write");
        wr(SLAVE_ADDR, 3, 32'h02778800, 5'h18, 1);
        outs(24'h000077);
        rd(1, 24'hff0000);
        RST = 1'b1;
        repeat (40) @(negedge CLK_SYS);
        RST = 1'b0;
        repeat (40) @(negedge CLK_SYS);
        outs(24'h000001);
        rd(1, 24'h000000);
        end_test("reset in mid-run");
        give_verdict();
    end
endmodule

`default_nettype wire
